/* lbpc_pkg.sv */
// Purpose: shared constants and carriers for the laser bias power control block
// Assumes: 12-bit converter codes, register port with one-cycle read latency
// Notes:   offsets are word indices on the plain register port
package lbpc_pkg;
   localparam int          LBPC_DW          = 12;
   localparam logic [3:0]  LBPC_A_CTRL      = 4'h0;
   localparam logic [3:0]  LBPC_A_TARGET    = 4'h1;
   localparam logic [3:0]  LBPC_A_CAL       = 4'h2;
   localparam logic [3:0]  LBPC_A_MON       = 4'h3;
   localparam logic [3:0]  LBPC_A_BIAS      = 4'h4;
   localparam logic [3:0]  LBPC_A_MOD       = 4'h5;
   localparam logic [3:0]  LBPC_A_TCOMP     = 4'h6;
   localparam logic [3:0]  LBPC_A_PWA       = 4'h7;
   localparam logic [3:0]  LBPC_A_STATUS    = 4'h8;
   // control bit positions
   localparam int          LBPC_B_CLOSED    = 0;
   localparam int          LBPC_B_PULSE_ADJUST_ENABLE    = 1;
   localparam int          LBPC_B_TEMP_EN   = 2;
   localparam logic [11:0] LBPC_CTRL_RST    = 12'h0000;
   localparam logic [11:0] LBPC_ZERO        = 12'h0000;
   localparam logic [11:0] LBPC_MAX         = 12'h0fff;
   localparam logic [11:0] LBPC_LOW_REF     = 12'h0010;
   localparam logic [11:0] LBPC_PWA_MID     = 12'h0800;
   localparam logic [11:0] LBPC_PWA_LO      = 12'h0333;
   localparam logic [11:0] LBPC_PWA_HI      = 12'h0ccc;
   localparam int          LBPC_INT_SHIFT   = 3;
   localparam int          LBPC_LOOP_CYC    = 16;

   typedef enum logic [1:0] {LBPC_IDLE, LBPC_SAMPLE, LBPC_FILTER, LBPC_STEP} lbpc_state_e;

   typedef struct packed {
      logic [3:0]  addr;
      logic [11:0] wdata;
      logic        wr;
      logic        rd;
   } lbpc_bus_s;

   typedef struct packed {
      logic [11:0] bias;
      logic [11:0] mod;
      logic [11:0] pulse_width_adjuster;
      logic        low_rate;
      logic        mod_disc;
      logic        low_ref;
   } lbpc_drive_s;
endpackage : lbpc_pkg

/* lbpc_top.sv */
// Purpose: closed/open loop bias control, powerdown handling, pulse and modulation settings
// Assumes: monitor samples arrive with a one-cycle valid strobe, temperature reading is used every cycle without one
// Notes:   registers on a plain address/strobe port, read data one cycle later
`timescale 1ns/10ps
`default_nettype none
module lbpc_top
   import lbpc_pkg::*;
#(
   parameter int LOOP_CYC = LBPC_LOOP_CYC
) (
   input  wire logic              I_REF_CLK,   // 25 MHz clock
   input  wire logic              I_RESET,     // async reset, active high
   input  wire lbpc_pkg::lbpc_bus_s I_BUS,     // register port request
   output logic [11:0]            O_RDATA,     // read data, cycle after read
   input  wire logic [11:0]       I_PD_SAMPLE, // mirrored photodiode current sample
   input  wire logic              I_PD_VALID,  // sample strobe
   input  wire logic [11:0]       I_TEMP,      // temperature reading
   input  wire logic              I_PWDN,      // powerdown/reset input
   input  wire logic              I_FAULT,     // safety fault, level
   output lbpc_pkg::lbpc_drive_s  O_DRIVE      // converter and mode drive
);
   import lbpc_pkg::*;

   initial begin
      if (LOOP_CYC < 2 || LOOP_CYC > 4096) begin
         $error("LOOP_CYC out of range");
      end
   end

   typedef struct packed {
      lbpc_state_e st;
      logic [11:0] ctrl;
      logic [11:0] target;
      logic [11:0] cal;
      logic [11:0] mon;
      logic [14:0] integ;
      logic [11:0] bias;
      logic [11:0] mod_set;
      logic [11:0] tcomp;
      logic [11:0] pwa_set;
      logic [11:0] rdata;
      logic [12:0] tick;
      lbpc_drive_s drv;
      logic        live;
   } lbpc_state_s;

   lbpc_state_s r;
   lbpc_state_s next_r;

   function automatic logic [11:0] sat_add(input logic [11:0] a, input logic [12:0] d_signed);
      logic [13:0] s;
      s = {2'b00, a} + {d_signed[12], d_signed};
      if (s[13]) begin
         sat_add = LBPC_ZERO;
      end else if (s[12]) begin
         sat_add = LBPC_MAX;
      end else begin
         sat_add = s[11:0];
      end
   endfunction : sat_add

   logic [11:0] filt;
   logic [12:0] err;
   logic [12:0] step;
   logic [23:0] tprod;
   logic [11:0] mod_eff;
   logic [11:0] pwa_eff;

   always_comb begin
      filt  = r.integ[14:3];
      err   = {1'b0, r.cal} - {1'b0, filt};
      step  = err[12] ? 13'h1fff : ((err == 13'h0000) ? 13'h0000 : 13'h0001);
      // ratio is tcomp/256 of the temperature reading
      tprod = I_TEMP * r.tcomp;
      // a ratio product above 12 bits saturates instead of being cut short
      mod_eff = !r.ctrl[LBPC_B_TEMP_EN] ? r.mod_set :
                (|tprod[23:20]) ? LBPC_MAX : sat_add(r.mod_set, {1'b0, tprod[19:8]});
      // pulse width clamp
      // span limits keep the adjuster inside its usable window
      if (!r.ctrl[LBPC_B_PULSE_ADJUST_ENABLE]) begin
         pwa_eff = LBPC_PWA_MID;
      end else if (r.pwa_set < LBPC_PWA_LO) begin
         pwa_eff = LBPC_PWA_LO;
      end else if (r.pwa_set > LBPC_PWA_HI) begin
         pwa_eff = LBPC_PWA_HI;
      end else begin
         pwa_eff = r.pwa_set;
      end
   end

   always_comb begin
      next_r = r;
      next_r.rdata = LBPC_ZERO;
      next_r.live  = 1'b1;
      if (I_BUS.wr) begin
         case (I_BUS.addr)
            LBPC_A_CTRL:   next_r.ctrl    = I_BUS.wdata & 12'h0007;
            LBPC_A_TARGET: next_r.target  = I_BUS.wdata;
            LBPC_A_CAL:    next_r.cal     = I_BUS.wdata;
            LBPC_A_MOD:    next_r.mod_set = I_BUS.wdata;
            LBPC_A_TCOMP:  next_r.tcomp   = I_BUS.wdata;
            LBPC_A_PWA:    next_r.pwa_set = I_BUS.wdata;
            default:       next_r.ctrl    = r.ctrl;
         endcase
      end
      if (I_BUS.rd) begin
         case (I_BUS.addr)
            LBPC_A_CTRL:   next_r.rdata = r.ctrl;
            LBPC_A_TARGET: next_r.rdata = r.target;
            LBPC_A_CAL:    next_r.rdata = r.cal;
            LBPC_A_MON:    next_r.rdata = r.mon;
            LBPC_A_BIAS:   next_r.rdata = r.bias;
            LBPC_A_MOD:    next_r.rdata = r.mod_set;
            LBPC_A_TCOMP:  next_r.rdata = r.tcomp;
            LBPC_A_PWA:    next_r.rdata = r.pwa_set;
            LBPC_A_STATUS: next_r.rdata = {8'h00, I_PWDN, I_FAULT, 2'(r.st)};
            default:       next_r.rdata = LBPC_ZERO;
         endcase
      end
      if (I_PD_VALID) begin
         next_r.mon = I_PD_SAMPLE;
      end
      next_r.tick = (r.tick >= 13'(LOOP_CYC - 1)) ? 13'h0000 : r.tick + 13'h0001;
      if (r.ctrl[LBPC_B_CLOSED]) begin
         case (r.st)
            LBPC_IDLE: begin
               if (r.tick == 13'h0000) begin
                  next_r.st = LBPC_SAMPLE;
               end
            end
            LBPC_SAMPLE: next_r.st = LBPC_FILTER;
            LBPC_FILTER: begin
               next_r.integ = r.integ - {3'b000, r.integ[14:3]} + {3'b000, r.mon};
               next_r.st    = LBPC_STEP;
            end
            LBPC_STEP: begin
               // bias follows calibrated target, not the setting
               next_r.bias = sat_add(r.bias, step);
               next_r.st   = LBPC_IDLE;
            end
            default: next_r.st = LBPC_IDLE;
         endcase
      end else begin
         next_r.st = LBPC_IDLE;
         // open loop: setting drives bias directly, firmware may rewrite
         next_r.bias = r.target;
      end
      next_r.drv.pulse_width_adjuster      = pwa_eff;
      next_r.drv.low_rate = I_PWDN;
      next_r.drv.low_ref  = I_PWDN;
      next_r.drv.mod_disc = I_PWDN;
      // bias held unless fault disables it or powerdown drops it to the low reference
      if (I_FAULT) begin
         next_r.drv.bias = LBPC_ZERO;
      end else if (I_PWDN) begin
         next_r.drv.bias = LBPC_LOW_REF;
      end else begin
         next_r.drv.bias = next_r.bias;
      end
      // modulation zeroed in powerdown or fault, else compensated
      if (I_FAULT || I_PWDN) begin
         next_r.drv.mod = LBPC_ZERO;
      end else begin
         next_r.drv.mod = mod_eff;
      end
   end

   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign O_RDATA = r.rdata;
   assign O_DRIVE = r.drv;

   // checks wait for live so no attempt straddles the reset release edge

   a_mon_update: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      I_PD_VALID |=> r.mon == $past(I_PD_SAMPLE))
      else $error("monitor not updated");

   a_mon_hold: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      !I_PD_VALID |=> r.mon == $past(r.mon))
      else $error("monitor changed without sample");

   a_mon_read: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (I_BUS.rd && I_BUS.addr == LBPC_A_MON) |=> O_RDATA == $past(r.mon))
      else $error("monitor read wrong");

   a_target_wr: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (I_BUS.wr && I_BUS.addr == LBPC_A_TARGET) |=> r.target == $past(I_BUS.wdata))
      else $error("target write lost");

   a_open_follow: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (!r.ctrl[0] && !I_BUS.wr) ##1 (!r.ctrl[0] && !I_BUS.wr) |=> r.bias == $past(r.target, 2))
      else $error("open loop bias not target");

   a_open_drive: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (!I_FAULT && !I_PWDN) |=> O_DRIVE.bias == r.bias)
      else $error("bias drive not held");

   a_pd_low: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (I_PWDN && !I_FAULT) |=> (O_DRIVE.low_rate && O_DRIVE.bias == LBPC_LOW_REF))
      else $error("powerdown bias wrong");

   a_pd_ref: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      I_PWDN |=> O_DRIVE.low_ref)
      else $error("low reference not selected");

   a_pd_leave: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      !I_PWDN |=> (!O_DRIVE.low_rate && !O_DRIVE.low_ref && !O_DRIVE.mod_disc))
      else $error("powerdown flags stuck");

   a_pd_mod: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      I_PWDN |=> O_DRIVE.mod == 12'h0000 && O_DRIVE.mod_disc)
      else $error("modulation not cut");

   a_fault_off: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      I_FAULT |=> O_DRIVE.bias == 12'h0000)
      else $error("fault did not disable bias");

   a_fault_mod: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      I_FAULT |=> O_DRIVE.mod == 12'h0000)
      else $error("fault did not disable modulation");

   a_pwa_mid: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      !r.ctrl[1] |=> O_DRIVE.pulse_width_adjuster == LBPC_PWA_MID)
      else $error("pulse adjust not mid");

   a_pwa_span: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      1'b1 |=> (O_DRIVE.pulse_width_adjuster >= LBPC_PWA_LO && O_DRIVE.pulse_width_adjuster <= LBPC_PWA_HI))
      else $error("pulse adjust out of span");

   a_pwa_pass: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (r.ctrl[1] && r.pwa_set >= LBPC_PWA_LO && r.pwa_set <= LBPC_PWA_HI) |=> O_DRIVE.pulse_width_adjuster == $past(r.pwa_set))
      else $error("pulse setting not applied");

   a_pwa_clamp: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (r.ctrl[1] && r.pwa_set < LBPC_PWA_LO) |=> O_DRIVE.pulse_width_adjuster == LBPC_PWA_LO)
      else $error("pulse setting not clamped");

   a_step_dir: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (r.ctrl[0] && r.st == LBPC_STEP && !err[12] && err != 13'h0000 && r.bias != 12'h0fff)
      |=> r.bias == $past(r.bias) + 12'h001)
      else $error("bias not stepped up");

   a_step_down: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (r.ctrl[0] && r.st == LBPC_STEP && err[12] && r.bias != 12'h0000)
      |=> r.bias == $past(r.bias) - 12'h001)
      else $error("bias not stepped down");

   a_filter_upd: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (r.ctrl[0] && r.st == LBPC_FILTER)
      |=> r.integ == $past(r.integ) - ($past(r.integ) >> 3) + 15'($past(r.mon)))
      else $error("integrator not updated");

   a_hold_eq: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (r.ctrl[0] && r.st == LBPC_STEP && err == 13'h0000) |=> r.bias == $past(r.bias))
      else $error("bias moved on target");

   a_closed_ignore: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (r.ctrl[0] && r.st != LBPC_STEP) |=> r.bias == $past(r.bias))
      else $error("closed loop bias moved off step");

   a_no_wrap: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (r.ctrl[0] && r.st == LBPC_STEP && r.bias == 12'h0fff && !err[12]) |=> r.bias == 12'h0fff)
      else $error("bias wrapped");

   a_no_under: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (r.ctrl[0] && r.st == LBPC_STEP && r.bias == 12'h0000 && (err[12] || err == 13'h0000))
      |=> r.bias == 12'h0000)
      else $error("bias wrapped below zero");

   a_loop_run: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (r.ctrl[0] && r.st == LBPC_SAMPLE) |=> r.st == LBPC_FILTER ##1 r.st == LBPC_STEP)
      else $error("loop sequence broken");

   a_loop_start: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (r.ctrl[0] && r.st == LBPC_IDLE && r.tick == 13'h0000) |=> r.st == LBPC_SAMPLE)
      else $error("loop did not start");

   a_idle_open: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      !r.ctrl[0] |=> r.st == LBPC_IDLE)
      else $error("state machine ran in open loop");

   a_temp_comp: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (!I_PWDN && !I_FAULT && !r.ctrl[2]) |=> O_DRIVE.mod == $past(r.mod_set))
      else $error("modulation wrong without comp");

   a_temp_add: assert property (@(posedge I_REF_CLK) disable iff (I_RESET || !r.live)
      (!I_PWDN && !I_FAULT && r.ctrl[2]) |=> O_DRIVE.mod >= $past(r.mod_set))
      else $error("compensated modulation below setting");

   c_closed: cover property (@(posedge I_REF_CLK) r.st == LBPC_STEP);
   c_pwdn: cover property (@(posedge I_REF_CLK) I_PWDN ##1 !I_PWDN);
   c_fault: cover property (@(posedge I_REF_CLK) I_FAULT && r.ctrl[0]);
   c_open: cover property (@(posedge I_REF_CLK) !r.ctrl[0] && O_DRIVE.bias != 12'h0000);
   c_pwa_hi: cover property (@(posedge I_REF_CLK) r.ctrl[1] && O_DRIVE.pulse_width_adjuster == LBPC_PWA_HI);
endmodule : lbpc_top
`default_nettype wire

/* lbpc_laser_model.sv */
// Purpose: laser, monitor photodiode and converter front end
// Assumes: photodiode sample is half the bias code
// Notes:   one sample every 4 cycles; temperature follows bench
`timescale 1ns/10ps
`default_nettype none
module lbpc_laser_model
   import lbpc_pkg::*;
(
   input  wire logic                i_clk,    // clock
   input  wire lbpc_pkg::lbpc_drive_s i_drive, // drive from block
   input  wire logic [11:0]         i_temp,   // bench temperature
   output logic [11:0]              o_sample, // photodiode sample
   output logic                     o_valid,  // sample strobe
   output logic [11:0]              o_temp    // temperature reading
);
   logic [1:0] cnt = 2'h0;
   always_ff @(posedge i_clk) begin
      cnt      <= cnt + 2'h1;
      o_valid  <= (cnt == 2'h3);
      // sample toggles between strobes so a stale read shows
      o_sample <= (cnt == 2'h3) ? {1'b0, i_drive.bias[11:1]} : ~o_sample;
      o_temp   <= i_temp;
   end
endmodule : lbpc_laser_model
`default_nettype wire

/* lbpc_tb.sv */
// Purpose: self-checking bench for the bias power control block
// Assumes: loop tick shortened to 2 cycles, so the closed loop steps every 4 cycles
// Notes:   front end model closes the loop
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import lbpc_pkg::*;
   logic        clk, rst, pwdn, fault, vld;
   lbpc_bus_s   bus;
   logic [11:0] rdata, temp, smp, tmp;
   lbpc_drive_s drv;
   int          err_count = 0;
   int          tests_run = 0;
   int          cyc       = 0;
   lbpc_top #(.LOOP_CYC(2)) i_lbpc_top (.I_REF_CLK(clk), .I_RESET(rst), .I_BUS(bus), .O_RDATA(rdata),
      .I_PD_SAMPLE(smp), .I_PD_VALID(vld), .I_TEMP(tmp), .I_PWDN(pwdn), .I_FAULT(fault), .O_DRIVE(drv));
   lbpc_laser_model i_lbpc_laser_model (.i_clk(clk), .i_drive(drv), .i_temp(temp), .o_sample(smp),
      .o_valid(vld), .o_temp(tmp));
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_rng(input logic [11:0] got, input logic [11:0] lo, input logic [11:0] hi);
      tests_run++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         err_count++;
         $display("ERROR %0t got %h out of range", $time, got);
      end
   endtask : chk_rng
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc
   task automatic wr(input logic [3:0] a, input logic [11:0] d);
      bus <= '{a, d, 1'b1, 1'b0};
      wait_cyc(1);
      bus <= '{a, d, 1'b0, 1'b0};
      wait_cyc(1);
   endtask : wr
   task automatic rdchk(input logic [3:0] a, input logic [11:0] e);
      bus <= '{a, 12'h0000, 1'b0, 1'b1};
      wait_cyc(1);
      bus <= '{a, 12'h0000, 1'b0, 1'b0};
      chk(rdata, e);
      wait_cyc(1);
   endtask : rdchk
   task automatic t_reset();
      chk(drv.bias, LBPC_ZERO);
      chk(drv.pulse_width_adjuster, LBPC_PWA_MID);
      rdchk(LBPC_A_CTRL, LBPC_CTRL_RST);
      wr(LBPC_A_BIAS, 12'h0abc);
      rdchk(LBPC_A_BIAS, LBPC_ZERO);
      rdchk(4'hf, LBPC_ZERO);
   endtask : t_reset
   task automatic t_open();
      wr(LBPC_A_TARGET, 12'h05a6);
      wait_cyc(2);
      chk(drv.bias, 12'h05a6);
      wait_cyc(8);
      rdchk(LBPC_A_MON, 12'h02d3);
      rdchk(LBPC_A_BIAS, 12'h05a6);
      wr(LBPC_A_TARGET, 12'h0fff);
      wait_cyc(2);
      chk(drv.bias, 12'h0fff);
      fault <= 1'b1;
      wait_cyc(2);
      chk(drv.bias, LBPC_ZERO);
      fault <= 1'b0;
      wait_cyc(2);
      chk(drv.bias, 12'h0fff);
      wait_cyc(8);
      rdchk(LBPC_A_MON, 12'h07ff);
   endtask : t_open
   task automatic t_pwdn();
      wr(LBPC_A_MOD, 12'h0123);
      pwdn <= 1'b1;
      wait_cyc(2);
      chk(drv.bias, LBPC_LOW_REF);
      chk(drv.mod, LBPC_ZERO);
      chk({9'h000, drv.low_rate, drv.low_ref, drv.mod_disc}, 12'h0007);
      pwdn <= 1'b0;
      wait_cyc(2);
      chk({9'h000, drv.low_rate, drv.low_ref, drv.mod_disc}, 12'h0000);
      chk(drv.bias, 12'h0fff);
      chk(drv.mod, 12'h0123);
   endtask : t_pwdn
   task automatic t_pwa();
      logic [11:0] s [3] = '{12'h0100, 12'h0500, 12'h0fff};
      logic [11:0] e [3] = '{LBPC_PWA_LO, 12'h0500, LBPC_PWA_HI};
      wr(LBPC_A_CTRL, 12'h0002);
      for (int i = 0; i < 3; i++) begin
         wr(LBPC_A_PWA, s[i]);
         wait_cyc(2);
         chk(drv.pulse_width_adjuster, e[i]);
      end
      wr(LBPC_A_CTRL, 12'h0000);
      wait_cyc(2);
      chk(drv.pulse_width_adjuster, LBPC_PWA_MID);
   endtask : t_pwa
   task automatic t_temp();
      wr(LBPC_A_MOD, 12'h0100);
      wr(LBPC_A_TCOMP, 12'h0080);
      temp <= 12'h0200;
      wr(LBPC_A_CTRL, 12'h0004);
      wait_cyc(3);
      chk(drv.mod, 12'h0200);
      wr(LBPC_A_MOD, 12'h0f00);
      temp <= 12'h0fff;
      wr(LBPC_A_TCOMP, 12'h0100);
      wait_cyc(3);
      chk(drv.mod, LBPC_MAX);
      wr(LBPC_A_CTRL, 12'h0000);
      wait_cyc(2);
      chk(drv.mod, 12'h0f00);
   endtask : t_temp
   task automatic t_closed();
      // out of reach target drives the code to its ceiling
      wr(LBPC_A_CAL, LBPC_MAX);
      wr(LBPC_A_TARGET, 12'h00aa);
      wr(LBPC_A_CTRL, 12'h0001);
      // one step per four cycles: about 3900 steps up from the open-loop code
      wait_cyc(16500);
      chk(drv.bias, LBPC_MAX);
      wr(LBPC_A_CAL, 12'h0400);
      wait_cyc(10000);
      chk_rng(drv.bias, 12'h07c0, 12'h0840);
      wr(LBPC_A_CAL, LBPC_ZERO);
      wait_cyc(10000);
      chk(drv.bias, LBPC_ZERO);
   endtask : t_closed
   task automatic results();
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // loop tests need about 37000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 45000) begin
         err_count++;
         results();
      end
   end
   initial begin
      rst   = 1'b1;
      pwdn  = 1'b0;
      fault = 1'b0;
      temp  = 12'h0000;
      bus   = '{4'h0, 12'h0000, 1'b0, 1'b0};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      wait_cyc(1);
      t_reset();
      t_open();
      t_pwdn();
      t_pwa();
      t_temp();
      t_closed();
      results();
   end
endmodule : testbench
`default_nettype wire
